/* design/mpu_sfr_port_flash_control.v */
// SFR bank of the MPU core: stack, data pointer, program counter, ports, MOVX stretch and flash control.
// Overview of operation
// - Stack top pointer is 8 bits, resets 0x07
// - Pointer increments before push, first byte 0x08
// - Data pointer: two independently loaded bytes, addresses memory
// - Program counter 16 bits, resets zero, increments
// - Latch bit drives its pin when output
// - Direction bit one means output, zero input
// - Port read returns actual pin state
// - Stretch field 0 to 7, reset value 1
// - EEPROM data and control registers read/write
// - Erase trigger write starts mass or page erase
// - Erase page 0 to 127, resets zero
// - Program write enable steers MOVX store via data pointer to flash
// - Mass erase enable write-only, cleared, rearmed each time
// - Engine protect blocks erase above engine location
// - Boot protect blocks erase below boot size
// - Security bit set-only, cleared only by reset
// - Read-only preboot status bit
// - Three-bit read/write flash bank select
`include "mpu_sfr_regs.vh"
module mpu_sfr_port_flash_control #(
	parameter PORT_WIDTH = 8,
	parameter PAGE_KB = 1
) (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire sfr_write,
	input wire sfr_read,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	input wire stack_push,
	input wire stack_pop,
	output reg [7:0] stack_top_pointer,
	output reg [15:0] data_pointer,
	input wire pc_increment,
	input wire pc_load,
	input wire [15:0] pc_load_value,
	output reg [15:0] program_counter,
	input wire [3*PORT_WIDTH-1:0] digital_io_pin_in,
	output reg [3*PORT_WIDTH-1:0] digital_io_pin_out,
	output reg [3*PORT_WIDTH-1:0] digital_io_pin_oe_n,
	input wire movx_start,
	input wire movx_write,
	input wire movx_via_data_pointer,
	input wire [15:0] movx_address,
	input wire [7:0] accumulator,
	input wire [7:0] shared_data_ram_rdata,
	output reg [15:0] mem_address,
	output reg [7:0] mem_wdata,
	output reg shared_data_ram_rd,
	output reg shared_data_ram_wr,
	output reg flash_program_wr,
	output reg movx_busy,
	output reg movx_done,
	output reg [7:0] movx_read_data,
	output reg [7:0] serial_eeprom_data,
	output reg [7:0] serial_eeprom_control,
	output reg eeprom_control_written,
	output reg [2:0] flash_bank_select,
	output reg mass_erase_start,
	output reg page_erase_start,
	output reg page_erase_refused,
	output reg [6:0] erase_page_number,
	output reg secure_mode,
	input wire preboot_active,
	input wire [6:0] engine_code_location,
	input wire [6:0] boot_size
);

	localparam PW = PORT_WIDTH;

	reg [PW-1:0] port_latch [0:2];
	reg [PW-1:0] port_direction [0:2];
	reg [2:0] movx_stretch_control;
	reg program_write_enable;
	reg mass_erase_enable;
	reg engine_area_erase_protect;
	reg boot_area_erase_protect;
	reg movx_state;
	reg [2:0] stretch_count;
	reg movx_is_write;
	reg movx_is_flash;
	reg [7:0] read_mux;
	reg page_blocked;
	wire [9:0] page_kb_start;
	wire [9:0] page_kb_end;
	wire [7:0] flash_control_view;

	// Maps a port index to the address of its latch.
	function [7:0] latch_addr;
		input integer idx;
		begin
			case (idx)
				0: latch_addr = `ADDR_PORT0_LATCH;
				1: latch_addr = `ADDR_PORT1_LATCH;
				default: latch_addr = `ADDR_PORT2_LATCH;
			endcase
		end
	endfunction

	// Maps a port index to the address of its direction register; note the odd order of port 0.
	function [7:0] dir_addr;
		input integer idx;
		begin
			case (idx)
				0: dir_addr = `ADDR_PORT0_DIR;
				1: dir_addr = `ADDR_PORT1_DIR;
				default: dir_addr = `ADDR_PORT2_DIR;
			endcase
		end
	endfunction

	// Decodes an SFR write strobe for one address.
	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		input strobe;
		begin
			wr_hit = strobe && (addr == target);
		end
	endfunction

	// Page bounds in kilobyte units, the unit of the protect thresholds.
	assign page_kb_start = erase_page_number * PAGE_KB[2:0];
	assign page_kb_end = page_kb_start + PAGE_KB[9:0];

	// The write-only mass erase enable reads back as zero, so software cannot poll it.
	assign flash_control_view = {preboot_active, secure_mode, boot_area_erase_protect, engine_area_erase_protect,
		2'b00, 1'b0, program_write_enable};

	// The boot area ends at boot_size*1024, so a page touching it is protected; the engine area
	// starts at engine_code_location*1024 and runs to the end of memory.
	// A page that only partly overlaps a protected area is refused as a whole.
	always @* begin
		page_blocked = 1'b0;
		if (engine_area_erase_protect && page_kb_end > {3'b000, engine_code_location}) begin
			page_blocked = 1'b1;
		end
		if (boot_area_erase_protect && page_kb_start < {3'b000, boot_size}) begin
			page_blocked = 1'b1;
		end
	end

	// Port latch addresses read the pins, so a pin driven as an output still shows its true level.
	always @* begin
		case (sfr_addr)
			`ADDR_PORT0_LATCH: read_mux = digital_io_pin_in[PW-1:0];
			`ADDR_PORT1_LATCH: read_mux = digital_io_pin_in[2*PW-1:PW];
			`ADDR_PORT2_LATCH: read_mux = digital_io_pin_in[3*PW-1:2*PW];
			`ADDR_PORT0_DIR: read_mux = port_direction[0];
			`ADDR_PORT1_DIR: read_mux = port_direction[1];
			`ADDR_PORT2_DIR: read_mux = port_direction[2];
			`ADDR_STACK_TOP: read_mux = stack_top_pointer;
			`ADDR_DATA_POINTER_LOW: read_mux = data_pointer[7:0];
			`ADDR_DATA_POINTER_HIGH: read_mux = data_pointer[15:8];
			`ADDR_STRETCH: read_mux = {5'b00000, movx_stretch_control};
			`ADDR_EEPROM_DATA: read_mux = serial_eeprom_data;
			`ADDR_EEPROM_CONTROL: read_mux = serial_eeprom_control;
			`ADDR_FLASH_CONTROL: read_mux = flash_control_view;
			`ADDR_BANK_SELECT: read_mux = {5'b00000, flash_bank_select};
			`ADDR_ERASE_PAGE: read_mux = {1'b0, erase_page_number};
			// The erase trigger is write-only and reads back as zero.
			`ADDR_ERASE_TRIGGER: read_mux = `RST_BYTE;
			default: read_mux = `RST_BYTE;
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= `RST_BYTE;
		end else if (sfr_read) begin
			// Read data holds until the next read, so the core may take it late.
			sfr_rdata <= read_mux;
		end
	end

	// Port latches and direction registers, one set per port.
	// Directions reset to zero so no pin drives until software asks for it.
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp = gp + 1) begin : port_bank
			always @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					port_latch[gp] <= {PW{1'b0}};
					port_direction[gp] <= {PW{1'b0}};
					digital_io_pin_out[gp*PW +: PW] <= {PW{1'b0}};
					digital_io_pin_oe_n[gp*PW +: PW] <= {PW{1'b1}};
				end else begin
					if (wr_hit(sfr_addr, latch_addr(gp), sfr_write)) begin
						port_latch[gp] <= sfr_wdata[PW-1:0];
					end
					if (wr_hit(sfr_addr, dir_addr(gp), sfr_write)) begin
						port_direction[gp] <= sfr_wdata[PW-1:0];
					end
					digital_io_pin_out[gp*PW +: PW] <= port_latch[gp];
					digital_io_pin_oe_n[gp*PW +: PW] <= ~port_direction[gp];
				end
			end
		end
	endgenerate

	// Core pointers; a software write takes priority over a core update in the same cycle.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stack_top_pointer <= `RST_STACK_TOP;
			data_pointer <= {`RST_BYTE, `RST_BYTE};
			program_counter <= `RST_PC;
		end else begin
			if (wr_hit(sfr_addr, `ADDR_STACK_TOP, sfr_write)) begin
				stack_top_pointer <= sfr_wdata;
			end else if (stack_push && !stack_pop) begin
				stack_top_pointer <= stack_top_pointer + 8'h01;
			end else if (stack_pop && !stack_push) begin
				stack_top_pointer <= stack_top_pointer - 8'h01;
			end
			if (wr_hit(sfr_addr, `ADDR_DATA_POINTER_LOW, sfr_write)) begin
				data_pointer[7:0] <= sfr_wdata;
			end
			if (wr_hit(sfr_addr, `ADDR_DATA_POINTER_HIGH, sfr_write)) begin
				data_pointer[15:8] <= sfr_wdata;
			end
			// A load wins over an increment so that a jump is never off by one.
			if (pc_load) begin
				program_counter <= pc_load_value;
			end else if (pc_increment) begin
				program_counter <= program_counter + 16'h0001;
			end
		end
	end

	// Configuration registers: stretch, bank select and erase page.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			movx_stretch_control <= `RST_STRETCH;
			flash_bank_select <= `RST_BANK;
			erase_page_number <= `RST_PAGE;
		end else begin
			if (wr_hit(sfr_addr, `ADDR_STRETCH, sfr_write)) begin
				movx_stretch_control <= sfr_wdata[`STRETCH_MSB:`STRETCH_LSB];
			end
			if (wr_hit(sfr_addr, `ADDR_BANK_SELECT, sfr_write)) begin
				flash_bank_select <= sfr_wdata[`BANK_MSB:0];
			end
			if (wr_hit(sfr_addr, `ADDR_ERASE_PAGE, sfr_write)) begin
				erase_page_number <= sfr_wdata[`PAGE_MSB:0];
			end
		end
	end

	// EEPROM interface registers; the pulse tells the EEPROM engine that a new command waits.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_eeprom_data <= `RST_BYTE;
			serial_eeprom_control <= `RST_BYTE;
			eeprom_control_written <= 1'b0;
		end else begin
			eeprom_control_written <= 1'b0;
			if (wr_hit(sfr_addr, `ADDR_EEPROM_DATA, sfr_write)) begin
				serial_eeprom_data <= sfr_wdata;
			end
			if (wr_hit(sfr_addr, `ADDR_EEPROM_CONTROL, sfr_write)) begin
				serial_eeprom_control <= sfr_wdata;
				eeprom_control_written <= 1'b1;
			end
		end
	end

	// Security is set-only: no software path clears it, only chip reset.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			secure_mode <= 1'b0;
		end else if (wr_hit(sfr_addr, `ADDR_FLASH_CONTROL, sfr_write) && sfr_wdata[`FC_SECURE]) begin
			secure_mode <= 1'b1;
		end
	end

	// Flash control bits and erase triggering.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			program_write_enable <= 1'b0;
			mass_erase_enable <= 1'b0;
			engine_area_erase_protect <= 1'b0;
			boot_area_erase_protect <= 1'b0;
			mass_erase_start <= 1'b0;
			page_erase_start <= 1'b0;
			page_erase_refused <= 1'b0;
		end else begin
			mass_erase_start <= 1'b0;
			page_erase_start <= 1'b0;
			page_erase_refused <= 1'b0;
			if (wr_hit(sfr_addr, `ADDR_FLASH_CONTROL, sfr_write)) begin
				program_write_enable <= sfr_wdata[`FC_PWE];
				mass_erase_enable <= sfr_wdata[`FC_MEEN];
				engine_area_erase_protect <= sfr_wdata[`FC_CE_PROT];
				boot_area_erase_protect <= sfr_wdata[`FC_BOOT_PROT];
			end else if (wr_hit(sfr_addr, `ADDR_ERASE_TRIGGER, sfr_write)) begin
				// The data written to the trigger carries no meaning and is dropped.
				// The enable is consumed by the trigger so that a stray second write cannot mass erase again.
				if (mass_erase_enable) begin
					mass_erase_start <= 1'b1;
					mass_erase_enable <= 1'b0;
				end else if (page_blocked) begin
					page_erase_refused <= 1'b1;
				end else begin
					page_erase_start <= 1'b1;
				end
			end
		end
	end

	// MOVX strobe sequencer; the strobe lasts one cycle plus the stretch value.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			movx_state <= `MOVX_IDLE;
			stretch_count <= 3'h0;
			movx_is_write <= 1'b0;
			movx_is_flash <= 1'b0;
			mem_address <= 16'h0000;
			mem_wdata <= `RST_BYTE;
			shared_data_ram_rd <= 1'b0;
			shared_data_ram_wr <= 1'b0;
			flash_program_wr <= 1'b0;
			movx_busy <= 1'b0;
			movx_done <= 1'b0;
			movx_read_data <= `RST_BYTE;
		end else begin
			movx_done <= 1'b0;
			case (movx_state)
				`MOVX_IDLE: begin
					if (movx_start) begin
						movx_state <= `MOVX_STROBE;
						// The stretch is captured here so a write during an access cannot change its length.
						stretch_count <= movx_stretch_control;
						movx_is_write <= movx_write;
						movx_is_flash <= movx_write && movx_via_data_pointer && program_write_enable;
						mem_address <= movx_via_data_pointer ? data_pointer : movx_address;
						mem_wdata <= accumulator;
						movx_busy <= 1'b1;
						shared_data_ram_rd <= !movx_write;
						shared_data_ram_wr <= movx_write && !(movx_via_data_pointer && program_write_enable);
						flash_program_wr <= movx_write && movx_via_data_pointer && program_write_enable;
					end
				end
				`MOVX_STROBE: begin
					if (stretch_count != 3'h0) begin
						stretch_count <= stretch_count - 3'h1;
					end else begin
						// Address stays put after the strobe drops, giving the hold time the RAM needs.
						movx_state <= `MOVX_IDLE;
						shared_data_ram_rd <= 1'b0;
						shared_data_ram_wr <= 1'b0;
						flash_program_wr <= 1'b0;
						movx_busy <= 1'b0;
						movx_done <= 1'b1;
						if (!movx_is_write) begin
							movx_read_data <= shared_data_ram_rdata;
						end
					end
				end
				default: begin
					movx_state <= `MOVX_IDLE;
				end
			endcase
		end
	end

endmodule

/* design/mpu_sfr_regs.vh */
// Register addresses, field positions, reset values and state codes for the SFR block.
`ifndef MPU_SFR_REGS_VH
`define MPU_SFR_REGS_VH
`define ADDR_PORT0_LATCH 8'h80
`define ADDR_STACK_TOP 8'h81
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_STRETCH 8'h8e
`define ADDR_PORT1_LATCH 8'h90
`define ADDR_PORT1_DIR 8'h91
`define ADDR_ERASE_TRIGGER 8'h94
`define ADDR_EEPROM_DATA 8'h9e
`define ADDR_EEPROM_CONTROL 8'h9f
`define ADDR_PORT2_LATCH 8'ha0
`define ADDR_PORT2_DIR 8'ha1
`define ADDR_PORT0_DIR 8'ha2
`define ADDR_FLASH_CONTROL 8'hb2
`define ADDR_BANK_SELECT 8'hb6
`define ADDR_ERASE_PAGE 8'hb7
`define RST_STACK_TOP 8'h07
`define RST_STRETCH 3'h1
`define RST_PC 16'h0000
`define RST_BYTE 8'h00
`define RST_PAGE 7'h00
`define RST_BANK 3'h0
`define FC_PWE 0
`define FC_MEEN 1
`define FC_CE_PROT 4
`define FC_BOOT_PROT 5
`define FC_SECURE 6
`define FC_PREBOOT 7
`define STRETCH_LSB 0
`define STRETCH_MSB 2
`define PAGE_MSB 6
`define BANK_MSB 2
`define MOVX_IDLE 1'b0
`define MOVX_STROBE 1'b1
`endif

/* tb/mpu_sfr_asserts.sv */
// Port-level assertions for the SFR block.
module mpu_sfr_asserts #(
	parameter PORT_WIDTH = 8
) (
	input logic sys_clk,
	input logic rst,
	input logic [7:0] sfr_addr,
	input logic sfr_write,
	input logic [7:0] sfr_wdata,
	input logic stack_push,
	input logic stack_pop,
	input logic [7:0] stack_top_pointer,
	input logic pc_increment,
	input logic pc_load,
	input logic [15:0] program_counter,
	input logic [3*PORT_WIDTH-1:0] digital_io_pin_out,
	input logic [3*PORT_WIDTH-1:0] digital_io_pin_oe_n,
	input logic movx_busy,
	input logic movx_done,
	input logic shared_data_ram_rd,
	input logic shared_data_ram_wr,
	input logic flash_program_wr,
	input logic [6:0] erase_page_number,
	input logic secure_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_push_pre_inc: assert property (stack_push && !stack_pop && !(sfr_write && sfr_addr == 8'h81)
		|=> stack_top_pointer == $past(stack_top_pointer) + 8'h01) else $error("push did not step pointer");
	a_pc_step: assert property (pc_increment && !pc_load
		|=> program_counter == $past(program_counter) + 16'h0001) else $error("counter did not step");
	a_pin_level: assert property (sfr_write && sfr_addr == 8'h80 ##1 !(sfr_write && sfr_addr == 8'h80)
		|=> digital_io_pin_out[7:0] == $past(sfr_wdata, 2)) else $error("pin level not latch");
	a_dir_enable: assert property (sfr_write && sfr_addr == 8'ha2 ##1 !(sfr_write && sfr_addr == 8'ha2)
		|=> digital_io_pin_oe_n[7:0] == ~$past(sfr_wdata, 2)) else $error("pin enable not direction");
	a_strobe_busy: assert property ((shared_data_ram_rd || shared_data_ram_wr || flash_program_wr)
		== movx_busy) else $error("strobe and busy differ");
	a_stretch_bound: assert property ($rose(movx_busy) |-> ##[1:8] movx_done)
		else $error("access longer than stretch allows");
	a_done_end: assert property (movx_done |-> $past(movx_busy) && !movx_busy)
		else $error("done not at strobe end");
	a_flash_path: assert property (flash_program_wr |-> !shared_data_ram_wr && !shared_data_ram_rd)
		else $error("flash and ram strobed together");
	a_secure_hold: assert property (secure_mode |=> secure_mode) else $error("secure bit cleared");
	a_page_load: assert property (sfr_write && sfr_addr == 8'hb7
		|=> erase_page_number == $past(sfr_wdata[6:0])) else $error("page number not loaded");
endmodule

bind mpu_sfr_port_flash_control mpu_sfr_asserts #(.PORT_WIDTH(PORT_WIDTH)) u_chk (.*);

/* tb/mpu_far_side.sv */
// Pins and shared data RAM as seen from outside the SFR block.
module mpu_far_side (
	input logic sys_clk,
	input logic [23:0] pin_out,
	input logic [23:0] oe_n,
	input logic [23:0] ext_level,
	input logic ram_rd,
	output logic [23:0] pin_in,
	output logic [7:0] ram_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] spin = 8'h00;
	assign pin_in = (~oe_n & pin_out) | (oe_n & ext_level);
	always @(posedge sys_clk) spin <= spin + 8'h3b;
	// Outside a read strobe the bus moves every cycle, so stale data cannot pass.
	assign ram_rdata = ram_rd ? 8'hc6 : spin;
endmodule

/* tb/tb.sv */
// Self-checking bench for the SFR block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, sfr_write, sfr_read, stack_push, stack_pop, pc_increment, pc_load;
	logic movx_start, movx_write, movx_via_data_pointer, shared_data_ram_rd, shared_data_ram_wr;
	logic flash_program_wr, movx_busy, movx_done, eeprom_control_written, mass_erase_start;
	logic page_erase_start, page_erase_refused, secure_mode, preboot_active;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, stack_top_pointer, accumulator, shared_data_ram_rdata;
	logic [7:0] mem_wdata, movx_read_data, serial_eeprom_data, serial_eeprom_control;
	logic [15:0] data_pointer, pc_load_value, program_counter, movx_address, mem_address, n;
	logic [23:0] digital_io_pin_in, digital_io_pin_out, digital_io_pin_oe_n, ext;
	logic [6:0] erase_page_number, engine_code_location, boot_size;
	logic [2:0] flash_bank_select;
	logic [3:0] fw = 4'h0;
	int err_total = 0;
	int checked = 0;
	mpu_sfr_port_flash_control u_dut (.*);
	mpu_far_side u_far (.sys_clk(sys_clk), .pin_out(digital_io_pin_out), .oe_n(digital_io_pin_oe_n),
		.ext_level(ext), .ram_rd(shared_data_ram_rd), .pin_in(digital_io_pin_in),
		.ram_rdata(shared_data_ram_rdata));
	always @(posedge sys_clk) if (flash_program_wr === 1'b1) fw <= fw + 4'h1;
	task close_out;
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{sfr_addr, sfr_wdata, sfr_write} = {a, d, 1'b1};
		@(negedge sys_clk);
		sfr_write = 1'b0;
	endtask
	task rdt(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		{sfr_addr, sfr_read} = {a, 1'b1};
		@(negedge sys_clk);
		sfr_read = 1'b0;
		chk(sfr_rdata, exp);
	endtask
	task mx(input logic w, input logic [2:0] s);
		@(negedge sys_clk);
		{movx_write, movx_start} = {w, 1'b1};
		@(negedge sys_clk);
		movx_start = 1'b0;
		n = 0;
		while (movx_busy === 1'b1 && n < 20) begin
			n++;
			@(negedge sys_clk);
		end
		chk(n, {13'h0, s} + 16'h1);
		chk(movx_done, 1'b1);
		if (n == 20) close_out();
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		rst = 1'b1;
		{sfr_write, sfr_read, stack_push, stack_pop, pc_increment, pc_load, movx_start, movx_write} = 8'h00;
		{preboot_active, movx_via_data_pointer, sfr_addr, sfr_wdata, accumulator} = {2'b01, 24'h00003e};
		{pc_load_value, movx_address, ext} = {16'h0000, 16'h0456, 24'ha5c3b7};
		{engine_code_location, boot_size} = {7'h04, 7'h02};
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		rdt(8'h81, 8'h07);
		rdt(8'h8e, 8'h01);
		rdt(8'hb7, 8'h00);
		chk(program_counter, 16'h0000);
		@(negedge sys_clk);
		{stack_push, pc_increment} = 2'b11;
		@(negedge sys_clk);
		stack_push = 1'b0;
		@(negedge sys_clk);
		pc_increment = 1'b0;
		chk(stack_top_pointer, 16'h0008);
		chk(program_counter, 16'h0002);
		stack_pop = 1'b1;
		@(negedge sys_clk);
		{stack_pop, pc_load, pc_increment, pc_load_value} = {3'b011, 16'h4321};
		@(negedge sys_clk);
		{pc_load, pc_increment} = 2'b00;
		chk(stack_top_pointer, 16'h0007);
		chk(program_counter, 16'h4321);
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		chk(data_pointer, 16'h1234);
		wr(8'h82, 8'hcd);
		chk(data_pointer, 16'h12cd);
		wr(8'h80, 8'h5a);
		wr(8'ha2, 8'h0f);
		@(negedge sys_clk);
		chk(digital_io_pin_out[7:0], 16'h005a);
		chk(digital_io_pin_oe_n[7:0], 16'h00f0);
		rdt(8'h80, {ext[7:4], 4'ha});
		wr(8'h90, 8'hc3);
		wr(8'h91, 8'hff);
		wr(8'ha0, 8'h3c);
		@(negedge sys_clk);
		chk(digital_io_pin_out[15:8], 16'h00c3);
		chk(digital_io_pin_oe_n[15:8], 16'h0000);
		chk(digital_io_pin_out[23:16], 16'h003c);
		chk(digital_io_pin_oe_n[23:16], 16'h00ff);
		rdt(8'h90, 8'hc3);
		rdt(8'ha0, ext[23:16]);
		wr(8'h9e, 8'h6b);
		wr(8'h9f, 8'h94);
		chk(eeprom_control_written, 1'b1);
		rdt(8'h9e, 8'h6b);
		chk(serial_eeprom_data, 16'h006b);
		rdt(8'h9f, 8'h94);
		wr(8'hb6, 8'hff);
		rdt(8'hb6, 8'h07);
		chk(flash_bank_select, 16'h0007);
		wr(8'hb2, 8'h02);
		wr(8'h94, 8'h00);
		chk(mass_erase_start, 1'b1);
		rdt(8'h94, 8'h00);
		wr(8'h94, 8'h00);
		chk({mass_erase_start, page_erase_start}, 2'b01);
		wr(8'hb7, 8'h01);
		wr(8'hb2, 8'h20);
		wr(8'h94, 8'h00);
		chk(page_erase_refused, 1'b1);
		wr(8'hb7, 8'h02);
		wr(8'h94, 8'h00);
		chk(page_erase_start, 1'b1);
		wr(8'hb2, 8'h10);
		wr(8'hb7, 8'h04);
		wr(8'h94, 8'h00);
		chk(page_erase_refused, 1'b1);
		wr(8'hb7, 8'h03);
		wr(8'h94, 8'h00);
		chk(page_erase_start, 1'b1);
		chk(erase_page_number, 16'h0003);
		preboot_active = 1'b1;
		wr(8'hb2, 8'h43);
		rdt(8'hb2, 8'hc1);
		wr(8'hb2, 8'h00);
		rdt(8'hb2, 8'hc0);
		chk(secure_mode, 1'b1);
		wr(8'h8e, 8'h00);
		mx(1'b0, 3'd0);
		chk(movx_read_data, 16'h00c6);
		wr(8'h8e, 8'h07);
		mx(1'b0, 3'd7);
		wr(8'h8e, 8'h01);
		mx(1'b1, 3'd1);
		chk(fw, 16'h0000);
		wr(8'hb2, 8'h01);
		mx(1'b1, 3'd1);
		chk(fw, 16'h0002);
		chk(mem_wdata, 16'h003e);
		chk(mem_address, 16'h12cd);
		movx_via_data_pointer = 1'b0;
		mx(1'b1, 3'd1);
		chk(fw, 16'h0002);
		chk(mem_address, 16'h0456);
		close_out();
	end
endmodule
